// ==== pkg/jtl_pkg.sv ====
// jtl_pkg: constants for the transmit link alignment block
// assumes one octet per clk in 8b/10b modes, one 66-bit block per clk in 64b/66b
package jtl_pkg;
  // register byte offsets
  localparam logic [4:0] JTL_OFS_CTRL = 5'h00;
  localparam logic [4:0] JTL_OFS_CFG = 5'h04;
  localparam logic [4:0] JTL_OFS_STATUS = 5'h08;
  localparam logic [4:0] JTL_OFS_SYSREFCNT = 5'h0C;
  localparam logic [4:0] JTL_OFS_ILASCNT = 5'h10;
  // control fields
  localparam int JTL_CTRL_ENABLE = 0;
  localparam int JTL_CTRL_MODE64 = 1;
  localparam int JTL_CTRL_SCRAMBLE = 2;
  localparam logic [2:0] JTL_CTRL_RST = 3'h0;
  // config fields: frames-per-multiframe and octets-per-frame, minus one
  localparam int JTL_CFG_F_LSB = 0;
  localparam int JTL_CFG_K_LSB = 8;
  localparam logic [7:0] JTL_F_M1_RST = 8'h01;
  localparam logic [7:0] JTL_K_M1_RST = 8'h1F;
  // multiframe limits
  localparam logic [17:0] JTL_MF_OCT_MIN = 18'h0_0011;
  localparam logic [17:0] JTL_MF_OCT_MAX = 18'h0_0400;
  localparam logic [8:0] JTL_K_MAX = 9'h100;
  // control characters before 8b/10b encoding
  localparam logic [7:0] JTL_K28_0 = 8'h1C;
  localparam logic [7:0] JTL_K28_3 = 8'h7C;
  localparam logic [7:0] JTL_K28_4 = 8'h9C;
  localparam logic [7:0] JTL_K28_5 = 8'hBC;
  localparam logic [7:0] JTL_K28_7 = 8'hFC;
  localparam logic [7:0] JTL_SCR_F_OCT = 8'hFC;
  localparam logic [7:0] JTL_SCR_A_OCT = 8'h7C;
  // alignment sequence length in multiframes, minus one
  localparam logic [1:0] JTL_INITIAL_LANE_ALIGN_SEQ_MF_LAST = 2'h3;
  // 64b/66b framing
  localparam logic [4:0] JTL_MB_LAST = 5'h1F;
  localparam logic [4:0] JTL_EOEMB_BLK = 5'h16;
  localparam logic [4:0] JTL_EOMB_ZERO_FIRST = 5'h1B;
  localparam logic [1:0] JTL_HDR_ONE = 2'h2;
  localparam logic [1:0] JTL_HDR_ZERO = 2'h1;
  localparam int JTL_E = 1;
  localparam logic [14:0] JTL_SCR8_SEED = 15'h7FFF;
  localparam logic [57:0] JTL_SCR64_SEED = 58'h3FF_FFFF_FFFF_FFFF;
  // link states, gray coded along idle, cgs, initial_lane_align_seq, data
  typedef enum logic [1:0] {
    JTL_IDLE = 2'b00,
    JTL_CGS = 2'b01,
    JTL_INITIAL_LANE_ALIGN_SEQ = 2'b11,
    JTL_DATA = 2'b10
  } jtl_state_t;
endpackage

// ==== hdl/jtl_tx_link.sv ====
// jtl_tx_link: transmit link layer, multiframe/multiblock tracking and
// alignment character insertion for one lane, with an Avalon-MM register slave.
// assumes the 8b/10b encoder and serializer sit after laneOctet/laneBlock,
// and that sync and sysref come from pins outside this clock domain.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module jtl_tx_link (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic syncReqN,
  input wire logic sysref,
  input wire logic [7:0] txOctet,
  output logic octetReady,
  input wire logic [63:0] txBlock,
  output logic blockReady,
  output logic [7:0] laneOctet,
  output logic laneIsK,
  output logic laneOctetValid,
  output logic [65:0] laneBlock,
  output logic laneBlockValid,
  output logic lmfcEdge,
  output logic lemcEdge,
  output jtl_pkg::jtl_state_t linkState
);
  import jtl_pkg::*;

  // 8b/10b scrambler 1 + x^14 + x^15, most significant bit first
  function automatic logic [22:0] scr8(input logic [14:0] st,
                                       input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    logic b;
    s = st;
    o = 8'h00;
    b = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      b = d[i] ^ s[13] ^ s[14];
      o[i] = b;
      s = {s[13:0], b};
    end
    return {s, o};
  endfunction

  // 64b/66b scrambler 1 + x^39 + x^58, in transmit bit order
  function automatic logic [121:0] scr64(input logic [57:0] st,
                                         input logic [63:0] d);
    logic [57:0] s;
    logic [63:0] o;
    logic b;
    s = st;
    o = 64'h0000_0000_0000_0000;
    b = 1'b0;
    for (int i = 0; i < 64; i++) begin
      b = d[i] ^ s[38] ^ s[57];
      o[i] = b;
      s = {s[56:0], b};
    end
    return {s, o};
  endfunction

  // frame/multiframe sizing check for the selected encoding
  function automatic logic cfgLegal(input logic [7:0] fm1,
                                    input logic [7:0] km1,
                                    input logic m64);
    logic [8:0] f;
    logic [8:0] k;
    logic [17:0] prod;
    f = {1'b0, fm1} + 9'h001;
    k = {1'b0, km1} + 9'h001;
    prod = f * k;
    if (m64) begin
      // whole frames per 256-octet multiblock means F is a power of two
      return (f & (f - 9'h001)) == 9'h000;
    end
    return prod >= JTL_MF_OCT_MIN && prod <= JTL_MF_OCT_MAX &&
           k <= JTL_K_MAX;
  endfunction

  logic enable;
  logic mode64;
  logic scrSel;
  logic [7:0] fM1;
  logic [7:0] kM1;
  logic [15:0] sysrefCount;
  logic [15:0] ilasCount;
  logic busAck;
  logic syncMeta;
  logic syncLvl;
  logic syncPrev;
  logic refMeta;
  logic refLvl;
  logic refPrev;
  logic [7:0] octIdx;
  logic [7:0] frmIdx;
  logic [9:0] mfOct;
  logic [1:0] ilasMf;
  logic ilasPending;
  logic [7:0] prevLast;
  logic [14:0] scrState8;
  logic [4:0] blkIdx;
  logic [57:0] scrState64;
  jtl_state_t state;
  jtl_state_t next_state;

  wire cfgOk = cfgLegal(fM1, kM1, mode64);
  wire scrEn = mode64 | scrSel;
  wire syncRise = syncLvl & ~syncPrev;
  wire refRise = refLvl & ~refPrev;
  wire frameEnd = octIdx == fM1;
  wire mfEnd = frameEnd && frmIdx == kM1;
  wire mfStart = octIdx == 8'h00 && frmIdx == 8'h00;
  wire [22:0] scr8Out = scr8(scrState8, txOctet);
  wire [7:0] dataOct = scrEn ? scr8Out[7:0] : txOctet;
  wire [121:0] scr64Out = scr64(scrState64, txBlock);
  wire run64 = enable & mode64 & cfgOk;

  // bus slave: one wait cycle, answer on the second cycle of a request
  assign avs_waitrequest = (avs_read | avs_write) & ~busAck;
  wire busTake = (avs_read | avs_write) & busAck;
  wire aligned = avs_address[1:0] == 2'b00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busAck <= 1'b0;
    end else begin
      busAck <= (avs_read | avs_write) & ~busAck;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable <= JTL_CTRL_RST[JTL_CTRL_ENABLE];
      mode64 <= JTL_CTRL_RST[JTL_CTRL_MODE64];
      scrSel <= JTL_CTRL_RST[JTL_CTRL_SCRAMBLE];
      fM1 <= JTL_F_M1_RST;
      kM1 <= JTL_K_M1_RST;
    end else if (busTake && avs_write && aligned) begin
      if (avs_address == JTL_OFS_CTRL) begin
        enable <= avs_writedata[JTL_CTRL_ENABLE];
        mode64 <= avs_writedata[JTL_CTRL_MODE64];
        scrSel <= avs_writedata[JTL_CTRL_SCRAMBLE];
      end
      if (avs_address == JTL_OFS_CFG) begin
        fM1 <= avs_writedata[JTL_CFG_F_LSB +: 8];
        kM1 <= avs_writedata[JTL_CFG_K_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !busAck) begin
      // loaded in the wait cycle so the word stands at the taking edge
      avs_readdata <= 32'h0000_0000;
      if (aligned) begin
        case (avs_address)
          JTL_OFS_CTRL: begin
            avs_readdata <= {29'h0000_0000, scrSel, mode64, enable};
          end
          JTL_OFS_CFG: begin
            avs_readdata <= {16'h0000, kM1, fM1};
          end
          JTL_OFS_STATUS: begin
            avs_readdata <= {8'h00, frmIdx, 3'h0, blkIdx, 2'h0, ilasMf,
                             syncLvl, cfgOk, state};
          end
          JTL_OFS_SYSREFCNT: begin
            avs_readdata <= {16'h0000, sysrefCount};
          end
          JTL_OFS_ILASCNT: begin
            avs_readdata <= {16'h0000, ilasCount};
          end
          default: begin
            avs_readdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // pin synchronisers; the second stage and the third, edge-detect stage feed logic
  always_ff @(posedge clk) begin
    if (!rstn) begin
      syncMeta <= 1'b0;
      syncLvl <= 1'b0;
      syncPrev <= 1'b0;
      refMeta <= 1'b0;
      refLvl <= 1'b0;
      refPrev <= 1'b0;
    end else begin
      syncMeta <= syncReqN;
      syncLvl <= syncMeta;
      syncPrev <= syncLvl;
      refMeta <= sysref;
      refLvl <= refMeta;
      refPrev <= refLvl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sysrefCount <= 16'h0000;
    end else if (refRise) begin
      sysrefCount <= sysrefCount + 16'h0001;
    end
  end

  // local multiframe clock: one octet slot per clk, F*K slots per period
  always_ff @(posedge clk) begin
    if (!rstn || refRise) begin
      octIdx <= 8'h00;
      frmIdx <= 8'h00;
      mfOct <= 10'h000;
    end else if (frameEnd) begin
      octIdx <= 8'h00;
      frmIdx <= mfEnd ? 8'h00 : frmIdx + 8'h01;
      mfOct <= mfEnd ? 10'h000 : mfOct + 10'h001;
    end else begin
      octIdx <= octIdx + 8'h01;
      mfOct <= mfOct + 10'h001;
    end
  end

  // local extended multiblock clock, E fixed at one
  always_ff @(posedge clk) begin
    if (!rstn || refRise) begin
      blkIdx <= 5'h00;
    end else begin
      blkIdx <= blkIdx + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lmfcEdge <= 1'b0;
      lemcEdge <= 1'b0;
    end else begin
      lmfcEdge <= mfStart & ~mode64;
      lemcEdge <= blkIdx == 5'h00 && mode64;
    end
  end

  always_comb begin
    next_state = state;
    if (!enable || mode64 || !cfgOk) begin
      next_state = JTL_IDLE;
    end else begin
      case (state)
        JTL_IDLE: begin
          next_state = JTL_CGS;
        end
        JTL_CGS: begin
          // leave on the last slot so the sequence opens on slot zero
          if (ilasPending && syncLvl && mfEnd) begin
            next_state = JTL_INITIAL_LANE_ALIGN_SEQ;
          end
        end
        JTL_INITIAL_LANE_ALIGN_SEQ: begin
          if (!syncLvl) begin
            next_state = JTL_CGS;
          end else if (mfEnd && ilasMf == JTL_INITIAL_LANE_ALIGN_SEQ_MF_LAST) begin
            next_state = JTL_DATA;
          end
        end
        JTL_DATA: begin
          if (!syncLvl) begin
            next_state = JTL_CGS;
          end
        end
        default: begin
          next_state = JTL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= JTL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign linkState = state;

  // a rise seen while commas go out arms the sequence for the next edge
  always_ff @(posedge clk) begin
    if (!rstn || state != JTL_CGS) begin
      ilasPending <= 1'b0;
    end else if (!syncLvl) begin
      ilasPending <= 1'b0;
    end else if (syncRise) begin
      ilasPending <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || state != JTL_INITIAL_LANE_ALIGN_SEQ) begin
      ilasMf <= 2'h0;
    end else if (mfEnd) begin
      ilasMf <= ilasMf + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ilasCount <= 16'h0000;
    end else if (state == JTL_CGS && next_state == JTL_INITIAL_LANE_ALIGN_SEQ) begin
      ilasCount <= ilasCount + 16'h0001;
    end
  end

  // scrambler runs only over user data, so the sequence stays plain
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scrState8 <= JTL_SCR8_SEED;
    end else if (state == JTL_DATA && scrEn) begin
      scrState8 <= scr8Out[22:8];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || state != JTL_DATA) begin
      prevLast <= 8'h00;
    end else if (frameEnd) begin
      prevLast <= dataOct;
    end
  end

  assign octetReady = state == JTL_DATA;

  // lane octet stream
  always_ff @(posedge clk) begin
    if (!rstn) begin
      laneOctet <= JTL_K28_5;
      laneIsK <= 1'b0;
      laneOctetValid <= 1'b0;
    end else begin
      laneOctetValid <= state != JTL_IDLE;
      laneOctet <= JTL_K28_5;
      laneIsK <= 1'b1;
      case (state)
        JTL_CGS: begin
          laneOctet <= JTL_K28_5;
          laneIsK <= 1'b1;
        end
        JTL_INITIAL_LANE_ALIGN_SEQ: begin
          laneIsK <= 1'b0;
          laneOctet <= mfOct[7:0];
          if (mfStart) begin
            laneOctet <= JTL_K28_0;
            laneIsK <= 1'b1;
          end else if (mfEnd) begin
            laneOctet <= JTL_K28_3;
            laneIsK <= 1'b1;
          end else if (ilasMf == 2'h1) begin
            // configuration multiframe: marker then parameter octets
            case (mfOct)
              10'h001: begin
                laneOctet <= JTL_K28_4;
                laneIsK <= 1'b1;
              end
              10'h002: laneOctet <= fM1;
              10'h003: laneOctet <= kM1;
              10'h004: laneOctet <= {7'h00, scrEn};
              default: laneOctet <= mfOct[7:0];
            endcase
          end
        end
        JTL_DATA: begin
          laneOctet <= dataOct;
          laneIsK <= 1'b0;
          if (!scrEn && frameEnd && dataOct == prevLast) begin
            laneOctet <= mfEnd ? JTL_K28_3 : JTL_K28_7;
            laneIsK <= 1'b1;
          end else if (scrEn && mfEnd && dataOct == JTL_SCR_A_OCT) begin
            laneOctet <= JTL_K28_3;
            laneIsK <= 1'b1;
          end else if (scrEn && frameEnd && !mfEnd &&
                       dataOct == JTL_SCR_F_OCT) begin
            laneOctet <= JTL_K28_7;
            laneIsK <= 1'b1;
          end
        end
        default: begin
          laneIsK <= 1'b0;
        end
      endcase
    end
  end

  // 64b/66b: sync header stream carries the multiblock pilot only;
  // crc and fec content belongs to another block
  wire pilotBit = blkIdx == JTL_MB_LAST || blkIdx == JTL_EOEMB_BLK ||
                  blkIdx < JTL_EOMB_ZERO_FIRST;
  wire [1:0] hdr = pilotBit ? JTL_HDR_ONE : JTL_HDR_ZERO;

  assign blockReady = run64;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scrState64 <= JTL_SCR64_SEED;
    end else if (run64) begin
      scrState64 <= scr64Out[121:64];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      laneBlock <= {64'h0000_0000_0000_0000, JTL_HDR_ZERO};
      laneBlockValid <= 1'b0;
    end else begin
      laneBlockValid <= run64;
      if (run64) begin
        laneBlock <= {scr64Out[63:0], hdr};
      end
    end
  end

endmodule

// ==== tb/jtl_tx_link_props.sv ====
// jtl_tx_link_props: port-level checks for the transmit link block
// assumes it is bound to jtl_tx_link and sees only that module's ports
`timescale 1ns/1ns
module jtl_tx_link_props (
  input logic clk,
  input logic rstn,
  input logic [4:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic syncReqN,
  input logic sysref,
  input logic [7:0] txOctet,
  input logic octetReady,
  input logic [63:0] txBlock,
  input logic blockReady,
  input logic [7:0] laneOctet,
  input logic laneIsK,
  input logic laneOctetValid,
  input logic [65:0] laneBlock,
  input logic laneBlockValid,
  input logic lmfcEdge,
  input logic lemcEdge,
  input jtl_pkg::jtl_state_t linkState
);
  import jtl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_mf_edge;
    ##1 lmfcEdge;
  endsequence
  a_bus_one_wait: assert property (s_req |-> s_one_wait)
    else $error("bus request not answered after one wait cycle");
  a_comma_cgs: assert property (
    $past(linkState) == JTL_CGS && linkState == JTL_CGS
    |-> laneOctet == JTL_K28_5 && laneIsK)
    else $error("no comma while requesting sync");
  a_sync_drop_cgs: assert property (
    !syncReqN [*6] |-> linkState != JTL_INITIAL_LANE_ALIGN_SEQ && linkState != JTL_DATA)
    else $error("link kept running with sync held low");
  a_initial_lane_align_seq_on_edge: assert property (
    $rose(linkState == JTL_INITIAL_LANE_ALIGN_SEQ) |-> syncReqN ##0 s_mf_edge)
    else $error("alignment sequence off the multiframe edge");
  a_initial_lane_align_seq_first_char: assert property (
    $rose(linkState == JTL_INITIAL_LANE_ALIGN_SEQ)
    |-> ##[0:1] (laneOctet == JTL_K28_0 && laneIsK))
    else $error("alignment sequence does not open with K28.0");
  a_data_on_edge: assert property (
    $rose(linkState == JTL_DATA) |-> s_mf_edge)
    else $error("user data not started on a multiframe edge");
  a_ready_in_data: assert property (
    octetReady == (linkState == JTL_DATA))
    else $error("octet ready outside data state");
  a_octet_valid: assert property (
    laneOctetValid == ($past(linkState) != JTL_IDLE))
    else $error("lane octet valid wrong for link state");
  a_block_follow: assert property (
    laneBlockValid == $past(blockReady))
    else $error("lane block not one cycle after intake");
  a_hdr_compl: assert property (
    laneBlockValid
    |-> laneBlock[1:0] == JTL_HDR_ONE || laneBlock[1:0] == JTL_HDR_ZERO)
    else $error("block header bits not complementary");
  a_local_ext_multiblock_clock_period: assert property (
    lemcEdge |-> ##32 (lemcEdge || !blockReady))
    else $error("multiblock edge not every 32 blocks");
endmodule

// ==== tb/jtl_rx_model.sv ====
// jtl_rx_model: far-end receiver, holds the sync request until commas lock
// assumes the transmitter's multiframe edge stands in for its own, both
// being phased by the same sysref pulse
`timescale 1ns/1ns
module jtl_rx_model (
  input logic clk,
  input logic rstn,
  input logic [7:0] laneOctet,
  input logic laneIsK,
  input logic laneOctetValid,
  input logic lmfcEdge,
  input logic dropReq,
  output logic syncReqN
);
  import jtl_pkg::*;
  logic [2:0] commaRun;
  always_ff @(posedge clk) begin
    if (!rstn || dropReq) begin
      syncReqN <= 1'b0;
      commaRun <= 3'h0;
    end else if (!syncReqN) begin
      if (laneOctetValid && laneIsK && laneOctet == JTL_K28_5) begin
        if (commaRun != 3'h4) commaRun <= commaRun + 3'h1;
      end else begin
        commaRun <= 3'h0;
      end
      if (commaRun == 3'h4 && lmfcEdge) syncReqN <= 1'b1;
    end
  end
endmodule

// ==== tb/tb.sv ====
// tb: bus-driven test of the transmit link block with a receiver model
// assumes each bus request is answered after exactly one wait cycle
`timescale 1ns/1ns
`define CHK(g, e) chk((g) === (e), 32'(g), 32'(e))
module tb;
  import jtl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, syncReqN, octetReady, blockReady, laneIsK;
  logic laneOctetValid, laneBlockValid, lmfcEdge, lemcEdge;
  logic sysref = 1'b0;
  logic dropReq = 1'b0;
  logic [7:0] txOctet = 8'h55;
  logic [63:0] txBlock = 64'h0123_4567_89AB_CDEF;
  logic [7:0] laneOctet;
  logic [65:0] laneBlock;
  logic [63:0] prevBlk;
  jtl_state_t linkState;
  logic [31:0] rd;
  logic [8:0] ilasBuf [0:71];
  logic hdr [0:63];
  logic [7:0] cfgF [0:4] = '{8'h01, 8'h01, 8'h03, 8'h04, 8'h04};
  logic [7:0] cfgK [0:4] = '{8'h07, 8'h08, 8'hFF, 8'hCB, 8'hCC};
  logic cfgOk [0:4] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  int errCount = 0, checksDone = 0, ilasIdx = -1, dataIdx = 0, pend = -1;
  int lmfcCnt = 0, lmfcGap = 0, lemcCnt = 0, lemcGap = 0;
  int hdrIdx = 0, sameBlk = 0, n, run;
  bit dataOn = 0, hdrOn = 0;
  always #5 clk = ~clk;
  jtl_tx_link DUT (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .syncReqN(syncReqN),
    .sysref(sysref), .txOctet(txOctet), .octetReady(octetReady),
    .txBlock(txBlock), .blockReady(blockReady), .laneOctet(laneOctet),
    .laneIsK(laneIsK), .laneOctetValid(laneOctetValid),
    .laneBlock(laneBlock), .laneBlockValid(laneBlockValid),
    .lmfcEdge(lmfcEdge), .lemcEdge(lemcEdge), .linkState(linkState));
  jtl_rx_model u_rx (.clk(clk), .rstn(rstn), .laneOctet(laneOctet),
    .laneIsK(laneIsK), .laneOctetValid(laneOctetValid),
    .lmfcEdge(lmfcEdge), .dropReq(dropReq), .syncReqN(syncReqN));
  task automatic chk(input bit ok, input logic [31:0] g, e);
    checksDone++;
    if (!ok) begin
      errCount++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic closeOut();
    $display("errors=%0d checks=%0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // the strobe drops at the taking edge, so back-to-back calls idle a cycle
  task automatic busWait(output logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      k++;
      @(posedge clk);
    end
    d = avs_readdata;
    if (k == 20) errCount++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    busWait(x);
  endtask
  task automatic rdv(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    busWait(d);
  endtask
  task automatic waitState(input jtl_state_t s);
    int k;
    k = 0;
    while (linkState !== s && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) errCount++;
    #1;
  endtask
  // multiframe of 18 octets: two octets a frame, nine frames
  task automatic ilasCheck(input logic scramble_enable);
    logic [8:0] e;
    int p;
    `CHK(ilasIdx, 72);
    for (int i = 0; i < 72; i++) begin
      p = i % 18;
      e = {1'b0, 8'(p)};
      if (p == 0) e = {1'b1, JTL_K28_0};
      else if (p == 17) e = {1'b1, JTL_K28_3};
      else if (i / 18 == 1 && p == 1) e = {1'b1, JTL_K28_4};
      else if (i / 18 == 1 && p == 2) e = 9'h001;
      else if (i / 18 == 1 && p == 3) e = 9'h008;
      else if (i / 18 == 1 && p == 4) e = {8'h00, scramble_enable};
      `CHK(ilasBuf[i], e);
    end
  endtask
  function automatic logic [8:0] expOct(input int i);
    if (i % 2 == 0 || i == 1) return {1'b0, 8'h55};
    return (i % 18 == 17) ? {1'b1, JTL_K28_3} : {1'b1, JTL_K28_7};
  endfunction
  always @(posedge clk) begin
    lmfcCnt <= lmfcEdge ? 1 : lmfcCnt + 1;
    if (lmfcEdge) lmfcGap <= lmfcCnt;
    lemcCnt <= lemcEdge ? 1 : lemcCnt + 1;
    if (lemcEdge) lemcGap <= lemcCnt;
    if (ilasIdx < 0 && laneOctetValid && laneIsK && laneOctet == JTL_K28_0)
      ilasIdx = 0;
    if (ilasIdx >= 0 && ilasIdx < 72) begin
      ilasBuf[ilasIdx] = {laneIsK, laneOctet};
      ilasIdx++;
    end
    if (dataOn && pend >= 0) begin
      `CHK({laneIsK, laneOctet}, expOct(pend));
      pend = -1;
    end
    if (dataOn && octetReady === 1'b1 && dataIdx < 40) begin
      pend = dataIdx;
      dataIdx++;
    end
    if (hdrOn && laneBlockValid === 1'b1 && hdrIdx < 64) begin
      hdr[hdrIdx] = (laneBlock[1:0] == JTL_HDR_ONE);
      if (hdrIdx > 0 && laneBlock[65:2] === prevBlk) sameBlk++;
      prevBlk = laneBlock[65:2];
      hdrIdx++;
    end
  end
  initial begin
    #400000;
    errCount++;
    closeOut();
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdv(JTL_OFS_CTRL, rd);
    `CHK(rd, 32'h0000_0000);
    rdv(JTL_OFS_CFG, rd);
    `CHK(rd, 32'h0000_1F01);
    wr(5'h14, 32'h0000_0007);
    rdv(5'h14, rd);
    `CHK(rd, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(JTL_OFS_CFG, {16'h0000, cfgK[i], cfgF[i]});
      rdv(JTL_OFS_STATUS, rd);
      `CHK(rd[2], cfgOk[i]);
    end
    @(posedge clk);
    sysref <= 1'b1;
    repeat (3) @(posedge clk);
    sysref <= 1'b0;
    repeat (4) @(posedge clk);
    rdv(JTL_OFS_SYSREFCNT, rd);
    `CHK(rd, 32'h0000_0001);
    wr(JTL_OFS_CFG, 32'h0000_0801);
    wr(JTL_OFS_CTRL, 32'h0000_0005);
    waitState(JTL_DATA);
    `CHK(lmfcGap, 18);
    ilasCheck(1'b1);
    rdv(JTL_OFS_STATUS, rd);
    `CHK(rd[1:0], 2'b10);
    wr(JTL_OFS_CTRL, 32'h0000_0001);
    @(posedge clk);
    dropReq <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK(linkState, JTL_CGS);
    `CHK({laneIsK, laneOctet}, {1'b1, JTL_K28_5});
    ilasIdx = -1;
    dataOn = 1;
    @(posedge clk);
    dropReq <= 1'b0;
    waitState(JTL_DATA);
    ilasCheck(1'b0);
    rdv(JTL_OFS_ILASCNT, rd);
    `CHK(rd, 32'h0000_0002);
    repeat (60) @(posedge clk);
    #1;
    `CHK(dataIdx, 40);
    hdrOn = 1;
    wr(JTL_OFS_CTRL, 32'h0000_0003);
    repeat (80) @(posedge clk);
    #1;
    `CHK(lemcGap, 32);
    `CHK(hdrIdx, 64);
    `CHK(sameBlk, 0);
    n = 0;
    run = 0;
    for (int i = 0; i < 32; i++) begin
      n += !hdr[i];
      if (!hdr[i] && !hdr[i + 1] && !hdr[i + 2] && !hdr[i + 3]) run++;
      if (hdr[i] !== hdr[i + 32]) n += 100;
    end
    `CHK(n, 4);
    `CHK(run, 1);
    closeOut();
  end
endmodule
bind jtl_tx_link jtl_tx_link_props u_props (.clk(clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .syncReqN(syncReqN),
  .sysref(sysref), .txOctet(txOctet), .octetReady(octetReady),
  .txBlock(txBlock), .blockReady(blockReady), .laneOctet(laneOctet),
  .laneIsK(laneIsK), .laneOctetValid(laneOctetValid),
  .laneBlock(laneBlock), .laneBlockValid(laneBlockValid),
  .lmfcEdge(lmfcEdge), .lemcEdge(lemcEdge), .linkState(linkState));
